// ==== rtl/rrsc_device.sv ====
// Design decision made here: the serial slave port.
`timescale 1ns/1ps
`include "rrsc_regs.svh"
module rrsc_device #(
   // Arbitrary values
   parameter logic [3:0] SILICON_REV = 4'h2,
   parameter logic [3:0] PRODUCT_CODE = 4'h5
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Serial link
   rrsc_spi_if.device spi,
   // Synthesizer side
   output logic [4:0] synth_a_out,
   output logic [6:0] synth_n_out,
   output logic synth_manual,
   output logic [7:0] radio_control_out
);
   logic sck_q_reg, sck_q_next;
   logic [2:0] cnt_reg, cnt_next;
   logic first_reg, first_next;
   logic wr_reg, wr_next;
   logic load_reg, load_next;
   logic [5:0] addr_reg, addr_next;
   rrsc_pkg::rrsc_byte_t sh_in_reg, sh_in_next;
   rrsc_pkg::rrsc_byte_t sh_out_reg, sh_out_next;
   logic miso_reg, miso_next;
   logic oe_reg, oe_next;
   logic [4:0] a_reg, a_next;
   logic [6:0] n_reg, n_next;
   rrsc_pkg::rrsc_byte_t ctl_reg, ctl_next;
   rrsc_pkg::rrsc_byte_t chan_reg, chan_next;
   logic [4:0] sa_reg, sa_next;
   logic [6:0] sn_reg, sn_next;
   logic man_reg, man_next;
   logic rise, fall;
   rrsc_pkg::rrsc_byte_t byte_in;
   logic [6:0] chan_clamped;
   logic [11:0] chan_total;
   logic manual;
   logic [4:0] eff_a;
   logic [6:0] eff_n;
   rrsc_pkg::rrsc_byte_t rd_data;

   // Channel to divider mapping: total = base + clamped channel, split N:A
   always_comb
   begin
      chan_clamped = (chan_reg[6:0] > `RRSC_CHAN_MAX) ? `RRSC_CHAN_MAX
         : chan_reg[6:0];
      chan_total = `RRSC_CHAN_BASE + {5'h00, chan_clamped};
      manual = chan_reg[`RRSC_CHAN_MANUAL_BIT];
      eff_a = manual ? a_reg : chan_total[4:0];
      eff_n = manual ? n_reg : chan_total[11:5];
   end

   // Register read mux
   always_comb
   begin
      unique case (addr_reg)
         `RRSC_OFS_REV: rd_data = {SILICON_REV, PRODUCT_CODE};
         `RRSC_OFS_A: rd_data = {3'h0, eff_a};
         `RRSC_OFS_N: rd_data = {1'h0, eff_n};
         `RRSC_OFS_CTL: rd_data = ctl_reg;
         `RRSC_OFS_CHAN: rd_data = chan_reg;
         default: rd_data = 8'h00;
      endcase
   end

   always_comb
   begin
      rise = spi.sck & ~sck_q_reg;
      fall = ~spi.sck & sck_q_reg;
      byte_in = {sh_in_reg[6:0], spi.mosi};
      sck_q_next = spi.sck;
      cnt_next = cnt_reg;
      first_next = first_reg;
      wr_next = wr_reg;
      load_next = load_reg;
      addr_next = addr_reg;
      sh_in_next = sh_in_reg;
      sh_out_next = sh_out_reg;
      miso_next = miso_reg;
      oe_next = oe_reg;
      a_next = a_reg;
      n_next = n_reg;
      ctl_next = ctl_reg;
      chan_next = chan_reg;
      if (spi.ss_n)
      begin
         cnt_next = 3'h0;
         first_next = 1'b1;
         load_next = 1'b0;
         oe_next = 1'b0;
         miso_next = 1'b0;
         sh_out_next = 8'h00;
      end
      else
      begin
         // Drive only while selected, so the line is shareable
         oe_next = 1'b1;
         if (rise)
         begin
            sh_in_next = byte_in;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7)
            begin
               if (first_reg)
               begin
                  first_next = 1'b0;
                  wr_next = byte_in[`RRSC_CMD_WRITE_BIT];
                  addr_next = byte_in[5:0];
                  load_next = ~byte_in[`RRSC_CMD_WRITE_BIT];
               end
               else if (wr_reg)
               begin
                  addr_next = addr_reg + 6'h01;
                  unique case (addr_reg)
                     `RRSC_OFS_A: a_next = byte_in[4:0];
                     `RRSC_OFS_N: n_next = byte_in[6:0];
                     `RRSC_OFS_CTL: ctl_next = byte_in;
                     `RRSC_OFS_CHAN: chan_next = byte_in;
                     default: ;
                  endcase
               end
               else
                  load_next = 1'b1;
            end
         end
         else if (fall)
         begin
            if (load_reg)
            begin
               sh_out_next = rd_data;
               miso_next = rd_data[7];
               addr_next = addr_reg + 6'h01;
               load_next = 1'b0;
            end
            else
            begin
               sh_out_next = {sh_out_reg[6:0], 1'b0};
               miso_next = sh_out_reg[6];
            end
         end
      end
      sa_next = eff_a;
      sn_next = eff_n;
      man_next = manual;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_q_reg <= 1'b0;
         cnt_reg <= 3'h0;
         first_reg <= 1'b1;
         wr_reg <= 1'b0;
         load_reg <= 1'b0;
         addr_reg <= 6'h00;
         sh_in_reg <= 8'h00;
         sh_out_reg <= 8'h00;
         miso_reg <= 1'b0;
         oe_reg <= 1'b0;
         a_reg <= `RRSC_A_RESET;
         n_reg <= `RRSC_N_RESET;
         ctl_reg <= `RRSC_CTL_RESET;
         chan_reg <= `RRSC_CHAN_RESET;
         sa_reg <= 5'h00;
         sn_reg <= 7'h00;
         man_reg <= 1'b0;
      end
      else
      begin
         sck_q_reg <= sck_q_next;
         cnt_reg <= cnt_next;
         first_reg <= first_next;
         wr_reg <= wr_next;
         load_reg <= load_next;
         addr_reg <= addr_next;
         sh_in_reg <= sh_in_next;
         sh_out_reg <= sh_out_next;
         miso_reg <= miso_next;
         oe_reg <= oe_next;
         a_reg <= a_next;
         n_reg <= n_next;
         ctl_reg <= ctl_next;
         chan_reg <= chan_next;
         sa_reg <= sa_next;
         sn_reg <= sn_next;
         man_reg <= man_next;
      end
   end

   assign spi.miso = miso_reg;
   assign spi.miso_oe = oe_reg;
   assign synth_a_out = sa_reg;
   assign synth_n_out = sn_reg;
   assign synth_manual = man_reg;
   assign radio_control_out = ctl_reg;
endmodule

// ==== rtl/rrsc_regs.svh ====
`ifndef RRSC_REGS_SVH
`define RRSC_REGS_SVH
// How it works
// - Revision upper nibble: read-only silicon revision
// - Revision lower nibble: fixed read-only product code
// - Host writes zeros to A reserved bits
// - Host keeps A divider within 0..31
// - Host writes zero to N reserved bit
// - Host keeps N divider within 74..76
// - Manual mode: synthesizer uses A and N
// - Channel bit 7 selects manual or channel
// - Channel mode: A/N reads show derived values
// - Host uses A/N only for diagnostics
// - Serial access, multi-byte least significant first

// Device register offsets
`define RRSC_OFS_REV 6'h00
`define RRSC_OFS_A 6'h01
`define RRSC_OFS_N 6'h02
`define RRSC_OFS_CTL 6'h03
`define RRSC_OFS_CHAN 6'h21

// Device field layout and reset values
`define RRSC_A_MASK 8'h1f
`define RRSC_N_MASK 8'h7f
`define RRSC_CHAN_MANUAL_BIT 7
`define RRSC_A_RESET 5'h00
`define RRSC_N_RESET 7'h00
`define RRSC_CTL_RESET 8'h00
`define RRSC_CHAN_RESET 8'h00

// Divider ranges and channel mapping
`define RRSC_A_MAX 8'h1f
`define RRSC_N_MIN 8'h4a
`define RRSC_N_MAX 8'h4c
`define RRSC_CHAN_MAX 7'h5f
`define RRSC_CHAN_BASE 12'h940

// Serial frame
`define RRSC_CMD_WRITE_BIT 7
`define RRSC_FRAME_BITS 5'h10

// Host register offsets (APB byte addresses)
`define RRSC_HOFS_CMD 12'h000
`define RRSC_HOFS_STATUS 12'h004
`define RRSC_HOFS_RDATA 12'h008
`define RRSC_HOFS_CTRL 12'h00c

// Host field positions
`define RRSC_HCMD_WRITE_BIT 16
`define RRSC_HST_BUSY_BIT 0
`define RRSC_HST_REFUSED_BIT 1
`define RRSC_HCTRL_DIAG_BIT 0
`endif

// ==== rtl/rrsc_pkg.sv ====
package rrsc_pkg;
   typedef enum logic [1:0] {RRSC_IDLE, RRSC_SHIFT, RRSC_GAP} rrsc_host_state_t;
   typedef logic [7:0] rrsc_byte_t;
endpackage

// ==== rtl/rrsc_spi_if.sv ====
`timescale 1ns/1ps
interface rrsc_spi_if;
   logic sck;
   logic ss_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_line;
   // Undriven line reads low
   assign miso_line = miso_oe & miso;
   modport device (input sck, input ss_n, input mosi, output miso,
      output miso_oe);
   modport host (output sck, output ss_n, output mosi, input miso_line);
endinterface

// ==== rtl/rrsc_host.sv ====
`timescale 1ns/1ps
`include "rrsc_regs.svh"
module rrsc_host #(
   parameter int HALF_PERIOD = 5
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link
   rrsc_spi_if.host spi
);
   // Eight-bit divider; one cycle per half outruns the device's edge sense
   if (HALF_PERIOD < 2 || HALF_PERIOD > 255)
   begin
      $error("HALF_PERIOD out of range");
   end

   rrsc_pkg::rrsc_host_state_t st_reg, st_next;
   logic [7:0] div_reg, div_next;
   logic [4:0] bit_reg, bit_next;
   logic [15:0] tx_reg, tx_next;
   rrsc_pkg::rrsc_byte_t rx_reg, rx_next;
   rrsc_pkg::rrsc_byte_t rdata_reg, rdata_next;
   logic sck_reg, sck_next, ss_n_reg, ss_n_next, mosi_reg, mosi_next;
   logic diag_reg, diag_next, refused_reg, refused_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic tick, wr_acc, mapped, cmd_wr, bad;
   logic [5:0] c_addr;
   rrsc_pkg::rrsc_byte_t c_data, c_sent;

   always_comb
   begin
      tick = (div_reg == 8'(HALF_PERIOD - 1));
      wr_acc = psel & penable & pready_reg & pwrite;
      mapped = (paddr == `RRSC_HOFS_CMD) || (paddr == `RRSC_HOFS_STATUS)
         || (paddr == `RRSC_HOFS_RDATA) || (paddr == `RRSC_HOFS_CTRL);
      cmd_wr = wr_acc & (paddr == `RRSC_HOFS_CMD);
      c_addr = pwdata[13:8];
      c_data = pwdata[7:0];
      c_sent = c_data;
      bad = 1'b0;
      if (pwdata[`RRSC_HCMD_WRITE_BIT] && c_addr == `RRSC_OFS_A)
      begin
         bad = ~diag_reg;
         if (c_data > `RRSC_A_MAX)
            bad = 1'b1;
         c_sent = c_data & `RRSC_A_MASK;
      end
      else if (pwdata[`RRSC_HCMD_WRITE_BIT] && c_addr == `RRSC_OFS_N)
      begin
         bad = ~diag_reg;
         if ((c_data & `RRSC_N_MASK) < `RRSC_N_MIN
            || (c_data & `RRSC_N_MASK) > `RRSC_N_MAX)
            bad = 1'b1;
         c_sent = c_data & `RRSC_N_MASK;
      end
   end

   // APB slave, one wait-free access phase
   always_comb
   begin
      pready_next = psel & ~penable;
      pslverr_next = psel & ~penable & ~mapped;
      prdata_next = 32'h0000_0000;
      diag_next = diag_reg;
      refused_next = refused_reg;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `RRSC_HOFS_STATUS: prdata_next = {30'h0, refused_reg,
               st_reg != rrsc_pkg::RRSC_IDLE};
            `RRSC_HOFS_RDATA: prdata_next = {24'h0, rdata_reg};
            `RRSC_HOFS_CTRL: prdata_next = {31'h0, diag_reg};
            default: prdata_next = 32'h0000_0000;
         endcase
      end
      if (wr_acc && paddr == `RRSC_HOFS_CTRL)
         diag_next = pwdata[`RRSC_HCTRL_DIAG_BIT];
      if (wr_acc && paddr == `RRSC_HOFS_STATUS
         && pwdata[`RRSC_HST_REFUSED_BIT])
         refused_next = 1'b0;
      // A new refusal wins over a clear
      if (cmd_wr && (bad || st_reg != rrsc_pkg::RRSC_IDLE))
         refused_next = 1'b1;
   end

   // Serial engine, mode 0, command byte then data byte
   always_comb
   begin
      st_next = st_reg;
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      bit_next = bit_reg;
      tx_next = tx_reg;
      rx_next = rx_reg;
      rdata_next = rdata_reg;
      sck_next = sck_reg;
      ss_n_next = ss_n_reg;
      mosi_next = mosi_reg;
      unique case (st_reg)
         rrsc_pkg::RRSC_IDLE:
         begin
            if (cmd_wr && !bad)
            begin
               // register access over the serial link
               st_next = rrsc_pkg::RRSC_SHIFT;
               tx_next = {pwdata[`RRSC_HCMD_WRITE_BIT], 1'b0, c_addr,
                  c_sent};
               mosi_next = pwdata[`RRSC_HCMD_WRITE_BIT];
               ss_n_next = 1'b0;
               bit_next = 5'h00;
               div_next = 8'h00;
            end
         end
         rrsc_pkg::RRSC_SHIFT:
         begin
            if (tick && !sck_reg)
            begin
               sck_next = 1'b1;
               rx_next = {rx_reg[6:0], spi.miso_line};
               bit_next = bit_reg + 5'h01;
            end
            else if (tick)
            begin
               sck_next = 1'b0;
               tx_next = {tx_reg[14:0], 1'b0};
               mosi_next = tx_reg[14];
               if (bit_reg == `RRSC_FRAME_BITS)
               begin
                  st_next = rrsc_pkg::RRSC_GAP;
                  ss_n_next = 1'b1;
                  rdata_next = rx_reg;
               end
            end
         end
         rrsc_pkg::RRSC_GAP:
         begin
            // Deselect gap lets the device clear its frame state
            mosi_next = 1'b0;
            if (tick)
               st_next = rrsc_pkg::RRSC_IDLE;
         end
         default: st_next = rrsc_pkg::RRSC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= rrsc_pkg::RRSC_IDLE;
         div_reg <= 8'h00;
         bit_reg <= 5'h00;
         tx_reg <= 16'h0000;
         rx_reg <= 8'h00;
         rdata_reg <= 8'h00;
         sck_reg <= 1'b0;
         ss_n_reg <= 1'b1;
         mosi_reg <= 1'b0;
         diag_reg <= 1'b0;
         refused_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         tx_reg <= tx_next;
         rx_reg <= rx_next;
         rdata_reg <= rdata_next;
         sck_reg <= sck_next;
         ss_n_reg <= ss_n_next;
         mosi_reg <= mosi_next;
         diag_reg <= diag_next;
         refused_reg <= refused_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign spi.sck = sck_reg;
   assign spi.ss_n = ss_n_reg;
   assign spi.mosi = mosi_reg;
endmodule

// ==== tb/rrsc_spi_assertions.sv ====
`timescale 1ns/1ps
module rrsc_spi_assertions #(
   parameter int HALF_PERIOD = 5
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Serial link
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   logic sck_reg, sck_next;
   logic [7:0] hi_reg, hi_next, lo_reg, lo_next;
   logic [5:0] rise_reg, rise_next;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Phase counters; low phase and rise count measured inside frames only, high phase whenever sck is high
   always_comb
   begin
      sck_next = sck;
      hi_next = sck ? hi_reg + 8'h01 : 8'h00;
      lo_next = (sck | ss_n) ? 8'h00 : lo_reg + 8'h01;
      rise_next = ss_n ? 6'h00 : rise_reg + {5'h00, sck & ~sck_reg};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_reg <= 1'b0;
         hi_reg <= 8'h00;
         lo_reg <= 8'h00;
         rise_reg <= 6'h00;
      end
      else
      begin
         sck_reg <= sck_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         rise_reg <= rise_next;
      end
   end

   property p_idle_sck;
      ss_n |-> !sck;
   endproperty
   a_idle_sck: assert property (p_idle_sck)
      else $error("serial clock moved outside a frame");
   property p_high_len;
      $fell(sck) |-> hi_reg == HALF_PERIOD;
   endproperty
   a_high_len: assert property (p_high_len)
      else $error("serial clock high phase has wrong length");
   property p_low_len;
      $rose(sck) |-> lo_reg == HALF_PERIOD;
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("serial clock low phase has wrong length");
   property p_frame_bits;
      $rose(ss_n) |-> rise_reg == 6'h10;
   endproperty
   a_frame_bits: assert property (p_frame_bits)
      else $error("frame does not hold sixteen bits");
   property p_mosi_hold;
      (sck && $past(sck)) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("host data changed while clock high");
   property p_miso_hold;
      (sck && $past(sck) && !ss_n) |-> $stable(miso);
   endproperty
   a_miso_hold: assert property (p_miso_hold)
      else $error("device data changed while clock high");
   property p_oe_follow;
      miso_oe == !$past(ss_n);
   endproperty
   a_oe_follow: assert property (p_oe_follow)
      else $error("device drive does not follow select");
   property p_min_frame;
      $fell(ss_n) |-> (!ss_n) [*8];
   endproperty
   a_min_frame: assert property (p_min_frame)
      else $error("select pulse too short");

   c_frame_end: cover property ($rose(ss_n));
   c_drive: cover property ($rose(miso_oe));
   c_miso_one: cover property (miso_line && !ss_n);
endmodule

// ==== tb/radio_revision_and_synth_counter_regs_tb_top.sv ====
`timescale 1ns/1ps
module radio_revision_and_synth_counter_regs_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, synth_manual, e;
   logic [4:0] synth_a_out;
   logic [6:0] synth_n_out;
   logic [7:0] radio_control_out;
   logic [11:0] t;
   logic [7:0] chans [4] = '{8'h00, 8'h05, 8'h20, 8'h7f};
   int err_count = 0;
   int total_checks = 0;

   rrsc_spi_if rrsc_spi_if_inst ();
   rrsc_host rrsc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .spi(rrsc_spi_if_inst.host));
   // Arbitrary code values
   rrsc_device #(.SILICON_REV(4'h3), .PRODUCT_CODE(4'hc)) rrsc_device_inst (
      .pclk(pclk), .presetn(presetn), .spi(rrsc_spi_if_inst.device),
      .synth_a_out(synth_a_out), .synth_n_out(synth_n_out),
      .synth_manual(synth_manual), .radio_control_out(radio_control_out));
   rrsc_spi_assertions #(.HALF_PERIOD(5)) rrsc_spi_assertions_inst (
      .pclk(pclk), .presetn(presetn), .sck(rrsc_spi_if_inst.sck),
      .ss_n(rrsc_spi_if_inst.ss_n), .mosi(rrsc_spi_if_inst.mosi),
      .miso(rrsc_spi_if_inst.miso), .miso_oe(rrsc_spi_if_inst.miso_oe),
      .miso_line(rrsc_spi_if_inst.miso_line));

   initial
   begin
      forever #25 pclk = ~pclk;
   end

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
         err_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Slave is polled at rising edges, no fixed wait assumed
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      // Answer taken at the very edge that shows pready high
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic dev(input logic wr, input logic [5:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      apb(1'b1, 12'h000, {15'h0000, wr, 2'b00, a, d});
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 200)
      begin
         apb(1'b0, 12'h004, 32'h0);
         n++;
      end
      if (n >= 200)
      begin
         err_count++;
         give_verdict();
      end
      if (!wr)
         apb(1'b0, 12'h008, 32'h0);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      dev(1'b0, a, 8'h00);
      chk({24'h0, q[7:0]}, {24'h0, exp});
   endtask

   // Reads and clears the refusal flag
   task automatic refused(input logic [31:0] exp);
      apb(1'b0, 12'h004, 32'h0);
      chk(q & 32'h2, exp);
      apb(1'b1, 12'h004, 32'h2);
   endtask

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(6'h00, 8'h3c);
      dev(1'b1, 6'h00, 8'h55);
      rd(6'h00, 8'h3c);
      rd(6'h03, 8'h00);
      foreach (chans[i])
      begin
         t = 12'h940 + (chans[i] > 8'h5f ? 12'h05f : {4'h0, chans[i]});
         dev(1'b1, 6'h21, chans[i]);
         rd(6'h01, {3'h0, t[4:0]});
         rd(6'h02, {1'b0, t[11:5]});
         chk({19'h0, synth_manual, synth_n_out, synth_a_out},
            {20'h0, t});
      end
      dev(1'b1, 6'h01, 8'h03);
      refused(32'h2);
      refused(32'h0);
      apb(1'b1, 12'h00c, 32'h1);
      dev(1'b1, 6'h21, 8'h80);
      dev(1'b1, 6'h01, 8'h1f);
      rd(6'h01, 8'h1f);
      dev(1'b1, 6'h02, 8'hca);
      rd(6'h02, 8'h4a);
      chk({19'h0, synth_manual, synth_n_out, synth_a_out},
         {19'h0, 1'b1, 7'h4a, 5'h1f});
      dev(1'b1, 6'h02, 8'h4d);
      refused(32'h2);
      dev(1'b1, 6'h01, 8'h20);
      refused(32'h2);
      dev(1'b1, 6'h02, 8'h4c);
      refused(32'h0);
      rd(6'h02, 8'h4c);
      // Second command lands while the first is still shifting
      apb(1'b1, 12'h000, {15'h0000, 1'b1, 2'b00, 6'h03, 8'ha5});
      dev(1'b1, 6'h03, 8'h5a);
      refused(32'h2);
      rd(6'h03, 8'ha5);
      chk({24'h0, radio_control_out}, 32'ha5);
      dev(1'b1, 6'h21, 8'h05);
      rd(6'h01, 8'h05);
      chk({31'h0, synth_manual}, 32'h0);
      rd(6'h3a, 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(6'h03, 8'h00);
      rd(6'h02, 8'h4a);
      give_verdict();
   end
endmodule
